// ==== core/sfb_burst_access.sv ====
/*
 * sfb_burst_access: device-side burst access logic of a synchronous
 * flash with an sdram-like command interface, plus its write buffer fifo.
 * Assumes: all inputs synchronous to clock; the array answers
 * array_rd_data combinationally for array_rd_loc_r; a program engine
 * drains the write buffer and reports prog_busy while it works.
 */
//
// Contract
// - first read word after latency, then every edge
// - data lines released when read burst ends
// - full page read wraps to column 0
// - new read follows or truncates without gaps
// - read accepted on every cycle, any bank
// - byte mask hits outputs two clocks later
// - write command forces data lines high impedance
// - byte mask on write data has zero latency
// - terminates cut read bursts, latency minus one
// - write words captured from command edge onward
// - after write burst, further input data ignored
// - write bursts 1,2,4,8 into write buffer
// - reads accepted after write is registered
// - active terminate: all banks or selected bank
// - active terminate is nop for other banks; code ends a write burst on an active terminate to any bank
// - power-down on clock gate low while idle
// - power-down left with nop and gate high
// - gate low suspends next internal edge
// - gate high resumes on following edge
// - single-write mode bit makes writes one column
// - read, write, burst terminate pin encodings
// - burst terminate hits most recent read burst
//
`timescale 1ns/10ps

// =====================================================================
// write buffer fifo
module sfb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic full_r;
    logic empty_r;
    logic push;
    logic pop;

    assign push = in_valid && !full_r;
    assign pop = out_ready && !empty_r;
    assign in_ready = !full_r;
    assign out_valid = !empty_r;
    assign out_data = mem_r[rd_ptr_r];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            always_ff @(posedge clock) begin
                if (push && wr_ptr_r == PW'(gi)) begin
                    mem_r[gi] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // full and empty are registered so in_ready never depends on the reader
    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
            full_r <= (count_r == (PW+1)'(DEPTH - 1));
            empty_r <= 1'b0;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
            full_r <= 1'b0;
            empty_r <= (count_r == (PW+1)'(1));
        end
    end
endmodule

// =====================================================================
// burst access top
module sfb_burst_access
    import sfb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_gate,
    input wire sfb_cmd_pins_type cmd_pins,
    input wire sfb_addr_type addr_pins,
    input wire logic [`SFB_MASK_W-1:0] byte_mask,
    input wire logic [`SFB_DATA_W-1:0] dq_in,
    output logic [`SFB_DATA_W-1:0] dq_out_r,
    output logic [`SFB_MASK_W-1:0] dq_oe_r,
    input wire logic [1:0] read_latency,
    input wire logic [2:0] burst_len_code,
    input wire logic single_write_mode_bit,
    output sfb_loc_type array_rd_loc_r,
    input wire logic [`SFB_DATA_W-1:0] array_rd_data,
    input wire logic prog_busy,
    output sfb_wr_word_type prog_word,
    output logic prog_valid,
    input wire logic prog_ready,
    output logic write_buffer_ready,
    output logic power_down_r,
    output logic buffers_off_r,
    output logic clock_suspended_r,
    output logic read_active_r
);
    sfb_cmd_type cmd;
    logic int_en;
    logic cke_prev_r;
    logic is_read;
    logic is_write;
    logic is_bterm;
    logic is_aterm;
    logic aterm_hit;
    logic rd_cut;
    logic full_page;
    logic [2:0] len_mask;
    logic [2:0] rd_left_r;
    logic rd_issue_r;
    logic rd_burst_r;
    sfb_loc_type rd_next;
    sfb_rd_stage_type pipe_r [2];
    sfb_rd_stage_type out_sel;
    logic [`SFB_MASK_W-1:0] mask_d1_r;
    logic [`SFB_MASK_W-1:0] mask_d2_r;
    logic wr_burst_r;
    logic [2:0] wr_left_r;
    sfb_loc_type wr_loc_r;
    logic [`SFB_COL_W-1:0] wr_col_nxt;
    logic wbuf_push;
    sfb_wr_word_type wbuf_word;
    logic access_busy;

    // =================================================================
    // command decode
    always_comb begin
        if (cmd_pins.cs_n) begin
            cmd = SFB_CMD_INHIBIT;
        end else begin
            unique case ({cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n})
                3'h7: cmd = SFB_CMD_NOP;
                3'h5: cmd = SFB_CMD_READ;
                3'h4: cmd = SFB_CMD_WRITE;
                3'h6: cmd = SFB_CMD_BURST_TERM;
                3'h2: cmd = SFB_CMD_ACTIVE_TERM;
                default: cmd = SFB_CMD_OTHER;
            endcase
        end
    end

    // commands count only on internal edges that are not suspended
    assign int_en = cke_prev_r;
    assign is_read = int_en && cmd == SFB_CMD_READ;
    assign is_write = int_en && cmd == SFB_CMD_WRITE;
    assign is_bterm = int_en && cmd == SFB_CMD_BURST_TERM;
    assign is_aterm = int_en && cmd == SFB_CMD_ACTIVE_TERM;
    // for a read burst, other banks see the active terminate as a no-op
    assign aterm_hit = is_aterm
        && (addr_pins.all_bank_terminate_bit
            || addr_pins.bank_select == array_rd_loc_r.bank);
    // burst terminate ignores the bank: it ends the latest read
    assign rd_cut = is_write || is_bterm || aterm_hit;

    assign full_page = burst_len_code == `SFB_BL_PAGE;

    always_comb begin
        unique case (burst_len_code)
            `SFB_BL_2: len_mask = 3'h1;
            `SFB_BL_4: len_mask = 3'h3;
            `SFB_BL_8: len_mask = 3'h7;
            default: len_mask = 3'h0;
        endcase
    end

    // =================================================================
    // clock gate, power-down and suspend
    always_ff @(posedge clock) begin
        if (rst) begin
            cke_prev_r <= 1'b1;
        end else begin
            cke_prev_r <= clock_gate;
        end
    end

    assign access_busy = rd_issue_r || pipe_r[0].valid || pipe_r[1].valid
        || (|dq_oe_r) || wr_burst_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            power_down_r <= 1'b0;
        end else if (power_down_r) begin
            if (clock_gate && (cmd == SFB_CMD_NOP || cmd == SFB_CMD_INHIBIT)) begin
                power_down_r <= 1'b0;
            end
        end else if (int_en && !clock_gate && !access_busy
                && (cmd == SFB_CMD_NOP || cmd == SFB_CMD_INHIBIT)) begin
            power_down_r <= 1'b1;
        end
    end

    // buffers stay on until the program engine has finished
    always_ff @(posedge clock) begin
        if (rst) begin
            buffers_off_r <= 1'b0;
        end else begin
            buffers_off_r <= power_down_r && !prog_busy;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clock_suspended_r <= 1'b0;
        end else begin
            clock_suspended_r <= !clock_gate && access_busy;
        end
    end

    // =================================================================
    // read address generator
    always_comb begin
        rd_next.bank = array_rd_loc_r.bank;
        if (full_page) begin
            // the page counter simply rolls over to column 0
            rd_next.column = array_rd_loc_r.column + 1'b1;
        end else begin
            rd_next.column = {array_rd_loc_r.column[`SFB_COL_W-1:3],
                ((array_rd_loc_r.column[2:0] + 3'h1) & len_mask)
                | (array_rd_loc_r.column[2:0] & ~len_mask)};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            array_rd_loc_r <= '0;
            rd_issue_r <= 1'b0;
            rd_burst_r <= 1'b0;
            rd_left_r <= `SFB_LEFT_RST;
        end else if (int_en) begin
            if (is_read) begin
                // a new read replaces the running one with no gap
                array_rd_loc_r.bank <= addr_pins.bank_select;
                array_rd_loc_r.column <= addr_pins.column;
                rd_issue_r <= 1'b1;
                rd_burst_r <= full_page || len_mask != 3'h0;
                rd_left_r <= len_mask;
            end else if (rd_cut) begin
                rd_issue_r <= 1'b0;
                rd_burst_r <= 1'b0;
            end else if (rd_burst_r) begin
                array_rd_loc_r <= rd_next;
                rd_issue_r <= 1'b1;
                if (!full_page) begin
                    rd_left_r <= rd_left_r - 3'h1;
                    rd_burst_r <= rd_left_r != 3'h1;
                end
            end else begin
                rd_issue_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            read_active_r <= 1'b0;
        end else begin
            read_active_r <= rd_issue_r || pipe_r[0].valid || pipe_r[1].valid;
        end
    end

    // =================================================================
    // read data pipeline; depth chosen by the read latency
    always_ff @(posedge clock) begin
        if (rst) begin
            pipe_r[0] <= '0;
            pipe_r[1] <= '0;
        end else if (int_en) begin
            if (is_write) begin
                pipe_r[0].valid <= 1'b0;
                pipe_r[1].valid <= 1'b0;
            end else begin
                pipe_r[0].valid <= rd_issue_r;
                pipe_r[0].data <= array_rd_data;
                pipe_r[1] <= pipe_r[0];
            end
        end
    end

    always_comb begin
        unique case (read_latency)
            `SFB_RL_2: out_sel = pipe_r[0];
            `SFB_RL_3: out_sel = pipe_r[1];
            default: out_sel = '{valid: rd_issue_r, data: array_rd_data};
        endcase
    end

    // =================================================================
    // output mask delay: two internal edges
    always_ff @(posedge clock) begin
        if (rst) begin
            mask_d1_r <= '1;
            mask_d2_r <= '1;
        end else if (int_en) begin
            mask_d1_r <= byte_mask;
            mask_d2_r <= mask_d1_r;
        end
    end

    // =================================================================
    // data output drivers; a suspended edge keeps driven data as is
    always_ff @(posedge clock) begin
        if (rst) begin
            dq_out_r <= '0;
            dq_oe_r <= '0;
        end else if (int_en) begin
            dq_out_r <= out_sel.data;
            if (is_write) begin
                dq_oe_r <= '0;
            end else if (out_sel.valid) begin
                dq_oe_r <= ~mask_d2_r;
            end else begin
                dq_oe_r <= '0;
            end
        end
    end

    // =================================================================
    // write burst capture into the write buffer
    assign wr_col_nxt = {wr_loc_r.column[`SFB_COL_W-1:3],
        ((wr_loc_r.column[2:0] + 3'h1) & len_mask) | (wr_loc_r.column[2:0] & ~len_mask)};

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_burst_r <= 1'b0;
            wr_left_r <= `SFB_LEFT_RST;
            wr_loc_r <= '0;
        end else if (int_en) begin
            if (is_write) begin
                wr_loc_r.bank <= addr_pins.bank_select;
                wr_loc_r.column <= {addr_pins.column[`SFB_COL_W-1:3],
                    (addr_pins.column[2:0] + 3'h1) & len_mask
                    | addr_pins.column[2:0] & ~len_mask};
                // single-write mode and page length both mean one column
                wr_burst_r <= !single_write_mode_bit
                    && !full_page && len_mask != 3'h0;
                wr_left_r <= len_mask - 3'h1;
            end else if (is_read || is_bterm || is_aterm) begin
                wr_burst_r <= 1'b0;
            end else if (wr_burst_r) begin
                wr_loc_r.column <= wr_col_nxt;
                wr_left_r <= wr_left_r - 3'h1;
                wr_burst_r <= wr_left_r != 3'h0;
            end
        end
    end

    // words land the same edge as the command and the mask has no delay
    always_comb begin
        wbuf_push = 1'b0;
        wbuf_word.mask = byte_mask;
        wbuf_word.data = dq_in;
        wbuf_word.loc.bank = addr_pins.bank_select;
        wbuf_word.loc.column = addr_pins.column;
        if (is_write) begin
            wbuf_push = byte_mask != '1;
        end else if (wr_burst_r && int_en && !(is_read || is_bterm || is_aterm)) begin
            wbuf_push = byte_mask != '1;
            wbuf_word.loc = wr_loc_r;
        end
    end

    // a full buffer drops the word: the controller must watch its ready
    sfb_fifo #(
        .WIDTH($bits(sfb_wr_word_type)),
        .DEPTH(`SFB_WBUF_DEPTH)
    ) u_wbuf (
        .clock(clock),
        .rst(rst),
        .in_valid(wbuf_push),
        .in_ready(write_buffer_ready),
        .in_data(wbuf_word),
        .out_valid(prog_valid),
        .out_ready(prog_ready),
        .out_data(prog_word)
    );
endmodule

// ==== core/sfb_regs.svh ====
/*
 * sfb_regs.svh: constants of the synchronous flash burst access block:
 * widths, mode encodings and reset values.
 * Assumes it is included by its bare name from a package or module.
 */
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH

// =====================================================================
// widths and write buffer depth
`define SFB_DATA_W 16
`define SFB_MASK_W 2
`define SFB_COL_W 8
`define SFB_BANK_W 2
`define SFB_WBUF_DEPTH 4

// =====================================================================
// burst length codes on burst_len_code
`define SFB_BL_1 3'h0
`define SFB_BL_2 3'h1
`define SFB_BL_4 3'h2
`define SFB_BL_8 3'h3
`define SFB_BL_PAGE 3'h7

// =====================================================================
// read latency codes and reset values
`define SFB_RL_1 2'h1
`define SFB_RL_2 2'h2
`define SFB_RL_3 2'h3
`define SFB_LEFT_RST 3'h0

`endif

// ==== core/sfb_pkg.sv ====
/*
 * sfb_pkg: types shared by the burst access block and its bench.
 * Assumes sfb_regs.svh is on the include path.
 */
package sfb_pkg;
`include "sfb_regs.svh"

    // ==================================================================
    // command pins and address pins
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sfb_cmd_pins_type;

    typedef struct packed {
        logic all_bank_terminate_bit;
        logic [`SFB_BANK_W-1:0] bank_select;
        logic [`SFB_COL_W-1:0] column;
    } sfb_addr_type;

    typedef struct packed {
        logic [`SFB_BANK_W-1:0] bank;
        logic [`SFB_COL_W-1:0] column;
    } sfb_loc_type;

    // one captured write word, as it sits in the write buffer
    typedef struct packed {
        sfb_loc_type loc;
        logic [`SFB_MASK_W-1:0] mask;
        logic [`SFB_DATA_W-1:0] data;
    } sfb_wr_word_type;

    typedef struct packed {
        logic valid;
        logic [`SFB_DATA_W-1:0] data;
    } sfb_rd_stage_type;

    typedef enum logic [2:0] {
        SFB_CMD_INHIBIT,
        SFB_CMD_NOP,
        SFB_CMD_READ,
        SFB_CMD_WRITE,
        SFB_CMD_BURST_TERM,
        SFB_CMD_ACTIVE_TERM,
        SFB_CMD_OTHER
    } sfb_cmd_type;
endpackage

// ==== dv/sfb_array_model.sv ====
/*
 * sfb_array_model: array and program engine beside the burst access block.
 * Assumes one clock; stall holds the drain off so the write buffer fills.
 */
`timescale 1ns/10ps

// =====================================================================
// array and drain
module sfb_array_model
    import sfb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic stall,
    input wire sfb_loc_type array_rd_loc_r,
    output logic [`SFB_DATA_W-1:0] array_rd_data,
    input wire sfb_wr_word_type prog_word,
    input wire logic prog_valid,
    output logic prog_ready,
    output logic prog_busy
);
    sfb_wr_word_type got[$];
    // each word names its own location, so a wrong column shows at once
    assign array_rd_data = {4'h5, 2'h0, array_rd_loc_r.bank, array_rd_loc_r.column};
    assign prog_ready = !stall;
    assign prog_busy = stall && prog_valid;
    always @(posedge clock) begin
        if (!rst && prog_valid && prog_ready) begin
            got.push_back(prog_word);
        end
    end
endmodule

// ==== dv/sfb_burst_access_checker.sv ====
/*
 * sfb_burst_access_checker: concurrent checks on the burst access ports.
 * Assumes one clock domain; bound into every sfb_burst_access.
 */
`timescale 1ns/10ps

// =====================================================================
// checker
module sfb_burst_access_checker
    import sfb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_gate,
    input wire sfb_cmd_pins_type cmd_pins,
    input wire sfb_addr_type addr_pins,
    input wire logic [`SFB_MASK_W-1:0] byte_mask,
    input wire logic [`SFB_DATA_W-1:0] dq_out_r,
    input wire logic [`SFB_MASK_W-1:0] dq_oe_r,
    input wire logic [1:0] read_latency,
    input wire sfb_loc_type array_rd_loc_r,
    input wire logic prog_busy,
    input wire logic prog_valid,
    input wire logic power_down_r,
    input wire logic buffers_off_r,
    input wire logic clock_suspended_r,
    input wire logic read_active_r
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_read_addr: assert property (cmd_pins == 4'h5 && $past(clock_gate) |=>
        array_rd_loc_r == {$past(addr_pins.bank_select), $past(addr_pins.column)})
        else $error("read address not loaded");
    a_write_hiz: assert property (cmd_pins == 4'h4 && $past(clock_gate) |=>
        dq_oe_r == 2'h0) else $error("data lines driven after write");
    a_mask_oe: assert property ($past(clock_gate) && clock_gate && byte_mask == 2'h3
        ##1 clock_gate |-> ##2 dq_oe_r == 2'h0) else $error("output mask latency wrong");
    a_suspend_hold: assert property (read_active_r && !clock_gate |-> ##2
        $stable(dq_out_r) && $stable(dq_oe_r)) else $error("outputs moved in suspend");
    a_bt_cl1: assert property (cmd_pins == 4'h6 && $past(clock_gate)
        && clock_gate && read_latency == 2'h1 |-> ##2 dq_oe_r == 2'h0)
        else $error("burst not terminated");
    a_pd_entry: assert property (cmd_pins == 4'h7 && !clock_gate && $past(clock_gate)
        && !read_active_r && !prog_valid && dq_oe_r == 2'h0 |=> power_down_r)
        else $error("power-down not entered");
    a_pd_exit: assert property (power_down_r && clock_gate && cmd_pins == 4'h7
        |=> !power_down_r) else $error("power-down not left");
    a_buffers_kept: assert property (prog_busy |=> !buffers_off_r)
        else $error("buffers off while programming");

    c_read: cover property (cmd_pins == 4'h5 ##1 read_active_r);
    c_write: cover property (cmd_pins == 4'h4 && $past(clock_gate));
    c_suspend: cover property ($rose(clock_suspended_r));
    c_power_down: cover property ($rose(power_down_r) ##[1:20] $fell(power_down_r));
endmodule

bind sfb_burst_access sfb_burst_access_checker sfb_burst_access_checker_i (.clock, .rst,
    .clock_gate, .cmd_pins, .addr_pins, .byte_mask, .dq_out_r, .dq_oe_r, .read_latency,
    .array_rd_loc_r, .prog_busy, .prog_valid, .power_down_r, .buffers_off_r,
    .clock_suspended_r, .read_active_r);

// ==== dv/sfb_burst_access_tb_top.sv ====
/*
 * sfb_burst_access_tb_top: directed scenarios for the burst access block.
 * Assumes the array model answers with a word that encodes its location.
 */
`timescale 1ns/10ps

// =====================================================================
// bench
module sfb_burst_access_tb_top
    import sfb_pkg::*;
();
    localparam logic [3:0] RD = 4'h5;
    localparam logic [3:0] WR = 4'h4;
    localparam logic [3:0] BT = 4'h6;
    localparam logic [3:0] NP = 4'h7;
    localparam logic [3:0] AT = 4'h2;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clock_gate = 1'b1;
    logic stall = 1'b0;
    sfb_cmd_pins_type cmd_pins = NP;
    sfb_addr_type addr_pins = '0;
    logic [`SFB_MASK_W-1:0] byte_mask = '0;
    logic [`SFB_DATA_W-1:0] dq_in = '0;
    logic [1:0] read_latency = 2'h2;
    logic [2:0] burst_len_code = 3'h2;
    logic single_write_mode_bit = 1'b0;
    logic [`SFB_DATA_W-1:0] dq_out_r, array_rd_data;
    logic [`SFB_MASK_W-1:0] dq_oe_r;
    sfb_loc_type array_rd_loc_r;
    sfb_wr_word_type prog_word;
    logic prog_valid, prog_ready, prog_busy, write_buffer_ready;
    logic power_down_r, buffers_off_r, clock_suspended_r, read_active_r;
    int mismatches = 0;
    int comparisons = 0;

    always #50 clock = ~clock;

    sfb_burst_access sfb_burst_access_i (.clock, .rst, .clock_gate, .cmd_pins, .addr_pins,
        .byte_mask, .dq_in, .dq_out_r, .dq_oe_r, .read_latency, .burst_len_code,
        .single_write_mode_bit, .array_rd_loc_r, .array_rd_data, .prog_busy, .prog_word,
        .prog_valid, .prog_ready, .write_buffer_ready, .power_down_r, .buffers_off_r,
        .clock_suspended_r, .read_active_r);
    sfb_array_model sfb_array_model_i (.clock, .rst, .stall, .array_rd_loc_r, .array_rd_data,
        .prog_word, .prog_valid, .prog_ready, .prog_busy);

    // =================================================================
    // shared tasks
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] exp_w(input logic [1:0] b, input logic [7:0] c);
        return {4'h5, 2'h0, b, c};
    endfunction

    task automatic cmd(input logic [3:0] p, input logic [1:0] b, input logic [7:0] c,
                       input logic ab);
        cmd_pins = p;
        addr_pins = {ab, b, c};
        @(negedge clock);
    endtask

    // returns where the first word is visible
    task automatic start_rd(input logic [1:0] b, input logic [7:0] c);
        cmd(RD, b, c, 1'b0);
        cmd_pins = NP;
        repeat (read_latency) @(negedge clock);
    endtask

    // burst words wrap inside an aligned block of len columns
    task automatic words(input logic [1:0] b, input logic [7:0] c0, input int len, input int n);
        logic [7:0] c;
        for (int i = 0; i < n; i++) begin
            if (i > 0) @(negedge clock);
            c = (c0 & ~8'(len - 1)) | 8'((c0 + i) & (len - 1));
            check(dq_out_r, exp_w(b, c));
            check(dq_oe_r, 2'h3);
        end
    endtask

    // =================================================================
    // scenarios
    task automatic sc_fixed_read();
        burst_len_code = `SFB_BL_4;
        start_rd(2'h1, 8'h06);
        words(2'h1, 8'h06, 4, 4);
        @(negedge clock);
        check(dq_oe_r, 2'h0);
    endtask

    task automatic sc_page_term();
        read_latency = 2'h1;
        burst_len_code = `SFB_BL_PAGE;
        start_rd(2'h2, 8'hfe);
        words(2'h2, 8'hfe, 256, 4);
        cmd(BT, 2'h0, 8'h00, 1'b0);
        cmd_pins = NP;
        check(dq_out_r, exp_w(2'h2, 8'h02));
        @(negedge clock);
        check(dq_oe_r, 2'h0);
    endtask

    task automatic sc_active_term();
        read_latency = 2'h2;
        for (int v = 0; v < 2; v++) begin
            start_rd(2'h1, 8'h00);
            words(2'h1, 8'h00, 256, 2);
            cmd(AT, 2'h3, 8'h00, 1'b0);
            check(dq_out_r, exp_w(2'h1, 8'h02));
            cmd(AT, 2'(v ^ 1), 8'h00, v[0]);
            cmd_pins = NP;
            check(dq_out_r, exp_w(2'h1, 8'h03));
            repeat (2) @(negedge clock);
            check(dq_oe_r, 2'h0);
        end
    endtask

    task automatic sc_mask_write();
        int idx[4] = '{0, 2, 3, 4};
        burst_len_code = `SFB_BL_8;
        stall = 1'b1;
        start_rd(2'h0, 8'h00);
        byte_mask = 2'h3;
        words(2'h0, 8'h00, 8, 3);
        @(negedge clock);
        check(dq_oe_r, 2'h0);
        byte_mask = 2'h0;
        repeat (2) begin
            @(negedge clock);
            check(dq_oe_r, 2'h0);
        end
        @(negedge clock);
        check(dq_out_r, exp_w(2'h0, 8'h06));
        dq_in = 16'hd000;
        cmd(WR, 2'h0, 8'h40, 1'b0);
        check(dq_oe_r, 2'h0);
        for (int i = 1; i < 12; i++) begin
            cmd_pins = NP;
            dq_in = 16'hd000 + 16'(i);
            byte_mask = (i == 1) ? 2'h3 : 2'h0;
            @(negedge clock);
        end
        check(write_buffer_ready, 1'b0);
        stall = 1'b0;
        for (int i = 0; i < 8; i++) begin
            dq_in = 16'hd100 + 16'(i);
            @(negedge clock);
        end
        check(sfb_array_model_i.got.size(), 4);
        for (int k = 0; k < 4; k++) begin
            check(sfb_array_model_i.got[k], {2'h0, 8'(8'h40 + idx[k]), 2'h0,
                16'(16'hd000 + idx[k])});
        end
    endtask

    task automatic sc_single_write();
        single_write_mode_bit = 1'b1;
        burst_len_code = `SFB_BL_4;
        dq_in = 16'he000;
        cmd(WR, 2'h2, 8'h81, 1'b0);
        for (int i = 1; i < 8; i++) begin
            cmd_pins = NP;
            dq_in = 16'he000 + 16'(i);
            @(negedge clock);
        end
        check(sfb_array_model_i.got.size(), 5);
        check(sfb_array_model_i.got[4], {2'h2, 8'h81, 2'h0, 16'he000});
        single_write_mode_bit = 1'b0;
        start_rd(2'h2, 8'h80);
        words(2'h2, 8'h80, 4, 4);
        @(negedge clock);
    endtask

    task automatic sc_back_to_back();
        read_latency = 2'h3;
        burst_len_code = `SFB_BL_2;
        cmd(RD, 2'h0, 8'h10, 1'b0);
        cmd(RD, 2'h3, 8'h21, 1'b0);
        cmd_pins = NP;
        repeat (2) @(negedge clock);
        check(dq_out_r, exp_w(2'h0, 8'h10));
        @(negedge clock);
        words(2'h3, 8'h21, 2, 2);
        @(negedge clock);
        check(dq_oe_r, 2'h0);
    endtask

    task automatic sc_suspend();
        read_latency = 2'h1;
        burst_len_code = `SFB_BL_8;
        start_rd(2'h0, 8'h08);
        clock_gate = 1'b0;
        words(2'h0, 8'h08, 8, 2);
        check(clock_suspended_r, 1'b1);
        clock_gate = 1'b1;
        @(negedge clock);
        check(dq_out_r, exp_w(2'h0, 8'h09));
        @(negedge clock);
        check(dq_out_r, exp_w(2'h0, 8'h0a));
        repeat (8) @(negedge clock);
        check(dq_oe_r, 2'h0);
    endtask

    task automatic sc_power_down();
        int n;
        clock_gate = 1'b0;
        for (n = 0; n < 8 && buffers_off_r !== 1'b1; n++) @(negedge clock);
        check(power_down_r, 1'b1);
        check(buffers_off_r, 1'b1);
        if (n == 8) end_of_test();
        clock_gate = 1'b1;
        @(negedge clock);
        check(power_down_r, 1'b0);
        start_rd(2'h1, 8'h33);
        words(2'h1, 8'h33, 8, 1);
        cmd(WR, 2'h1, 8'h00, 1'b0);
        cmd_pins = NP;
        check(dq_oe_r, 2'h0);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        sc_fixed_read();
        sc_page_term();
        sc_active_term();
        sc_mask_write();
        sc_single_write();
        sc_back_to_back();
        sc_suspend();
        sc_power_down();
        repeat (10) @(negedge clock);
        end_of_test();
    end
endmodule
